// *** src/diag_flag_defs.svh ***
`ifndef DIAG_FLAG_DEFS_SVH
`define DIAG_FLAG_DEFS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
// Core clock rate in MHz
`define CLK_FREQ_MHZ 25
// Select line low limit, 2.0 ms, held in microseconds
`define SEL_LOW_LIMIT_US 2000
// Limit in core clock cycles
`define SEL_LOW_LIMIT_CYCLES (`SEL_LOW_LIMIT_US * `CLK_FREQ_MHZ)

// ----------------------------------------------------------------
// Watchdog flash-mode fraction
// ----------------------------------------------------------------
// Flag point, percent of programmed period
`define WD_FLASH_PCT 7'd50
// Full period, percent
`define WD_FULL_PCT 7'd100

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
// Idle level of the active-low select line
`define SEL_IDLE_LEVEL 1'b1
// Flags come up clear
`define FLAG_RESET_VALUE 1'b0

`endif

// *** src/diag_flag_pkg.sv ***
package diag_flag_pkg;

    // ------------------------------------------------------------
    // Condition-backed fault flags
    // ------------------------------------------------------------
    typedef struct packed {
        logic canh_bat;    // High line short to battery
        logic canh_vdd;    // High line short to regulator
        logic canh_gnd;    // High line short to ground
        logic canl_bat;    // Low line short to battery
        logic canl_vdd;    // Low line short to regulator
        logic canl_gnd;    // Low line short to ground
        logic hs3_gnd;     // Fourth high-side switch short to ground
        logic hs2_gnd;     // Third high-side switch short to ground
        logic sup2_uv;     // Supply input two undervoltage
        logic sup1_ov;     // Supply input one overvoltage
        logic hs0_therm;   // First high-side switch overtemperature
    } fault_flags_s;

    // ------------------------------------------------------------
    // Event flags, cleared by a read alone
    // ------------------------------------------------------------
    typedef struct packed {
        logic parity_err;      // Frame parity error
        logic select_timeout;  // Select line held low too long
        logic wd_flash_half;   // Watchdog past half in flash mode
        logic wake_io13;       // Wake from inputs one or three
        logic wake_io02;       // Wake from inputs zero or two
        logic wake_spi;        // Wake by command, regulator on
        logic wake_forced;     // Timer forced wake-up
        logic int_timeout;     // Interrupt service timeout
        logic lp_off_seen;     // Regulator-off low power selected
        logic reset_request;   // Reset requested by command
        logic debug_exit;      // Debug left by pin voltage
    } event_flags_s;

    // Whole flag bank as read by the host
    typedef struct packed {
        fault_flags_s fault;
        event_flags_s evt;
    } flag_bank_s;

    // ------------------------------------------------------------
    // Event sources from internal state machines
    // ------------------------------------------------------------
    typedef struct packed {
        logic wake_io13;            // Wake seen on input one or three
        logic wake_io02;            // Wake seen on input zero or two
        logic spi_wake;             // Wake by command
        logic timer_forced_wakeup;  // Forced wake timer fired
        logic int_service_expired;  // Service timer ran out
        logic low_power_regulator_off_mode_select; // Mode selected
    } event_sources_s;

    // Select line timer states
    typedef enum logic [1:0] {
        SEL_IDLE    = 2'b00,
        SEL_TIMING  = 2'b01,
        SEL_EXPIRED = 2'b10
    } select_timer_e;

endpackage

// *** src/pulse_crossing.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Toggle-based single-pulse crossing between clock domains
// ----------------------------------------------------------------
module pulse_crossing (
    // Source side
    input wire logic src_clk,
    input wire logic src_pulse,
    // Destination side
    input wire logic dst_clk,
    output logic dst_pulse,
    // Shared asynchronous reset
    input wire logic rst_n
);

    // Destination state
    typedef struct packed {
        logic s1;     // First stage, read by s2 only
        logic s2;     // Second stage
        logic s3;     // Previous s2 for edge find
        logic pulse;  // Registered output pulse
    } dst_state_s;

    logic src_toggle;  // Flips once per source pulse
    dst_state_s st;
    dst_state_s next_st;

    // Source toggle; needs no edge after the pulse itself
    always_ff @(posedge src_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_toggle <= 1'b0;
        end else if (src_pulse) begin
            src_toggle <= ~src_toggle;
        end
    end

    // Destination next state
    always_comb begin
        next_st = st;
        next_st.s1 = src_toggle;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.pulse = st.s2 ^ st.s3;
    end

    // Destination registers
    always_ff @(posedge dst_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dst_pulse = st.pulse;

endmodule

// *** src/diag_flag_bank.sv ***
`timescale 1ns/1ns
`include "diag_flag_defs.svh"
// Functional notes
// R1: Six line-short flags; clear when gone and read
// R2: Switch two/three ground flags; recover plus read
// R3: Parity error sets flag; read clears
// R4: Select low beyond 2.0 ms sets flag
// R5: Supply flags clear after recovery and read
// R6: Switch zero thermal flag; cool plus read
// R7: Flash mode watchdog past half sets flag
// R8: Wake on inputs one/three sets shared flag
// R9: Wake on inputs zero/two sets shared flag
// R10: Command wake in regulator-on mode flagged
// R11: Timer forced wake-up sets flag
// R12: Service timer expiry sets flag
// R13: Regulator-off mode selection is remembered
// R14: Command-requested reset flagged after reset
// R15: Debug exit by pin voltage flagged
// R16: Real-time indicators untouched by reads
// R17: Read returns flags, clears, keeps new events
module diag_flag_bank #(
    parameter int CNT_W = 16,   // Select timer width
    parameter int SEL_TIMEOUT_CYCLES = `SEL_LOW_LIMIT_CYCLES,
    parameter int WD_W = 16,    // Watchdog count width
    parameter int RT_W = 8      // Real-time indicator width
) (
    // Core clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link side, on the serial clock
    input wire logic spi_clk,
    input wire logic link_flag_read,
    input wire logic link_parity_error,
    // Analog detectors, asynchronous
    input wire diag_flag_pkg::fault_flags_s fault_in,
    input wire logic spi_select_line_n,
    input wire logic debug_entry_pin_high,
    // Internal state, core clock
    input wire logic debug_mode_active,
    input wire logic flash_mode,
    input wire logic [WD_W-1:0] wd_elapsed,
    input wire logic [WD_W-1:0] wd_period,
    input wire diag_flag_pkg::event_sources_s evt_in,
    input wire logic low_power_regulator_on_mode,
    input wire logic reset_by_spi_request,
    input wire logic [RT_W-1:0] rt_state_in,
    // Flag outputs
    output diag_flag_pkg::flag_bank_s flags,
    output diag_flag_pkg::flag_bank_s read_data,
    output logic read_valid,
    output logic [RT_W-1:0] rt_state
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        diag_flag_pkg::fault_flags_s fault_s1;  // Sync stage one
        diag_flag_pkg::fault_flags_s fault_s2;  // Sync stage two
        logic sel_s1;                           // Select stage one
        logic sel_s2;                           // Select stage two
        diag_flag_pkg::select_timer_e sel_state;
        logic [CNT_W-1:0] sel_count;            // Cycles held low
        logic dbg_s1;                           // Pin stage one
        logic dbg_s2;                           // Pin stage two
        logic dbg_prev;                         // Pin last cycle
        logic wd_over;                          // Past half last cycle
        logic armed;                            // Set after first edge
        diag_flag_pkg::flag_bank_s flags;       // Latched flags
        diag_flag_pkg::flag_bank_s read_data;   // Snapshot at read
        logic read_valid;                       // Snapshot strobe
        logic [RT_W-1:0] rt;                    // Real-time copy
    } state_s;

    state_s st;
    state_s next_st;
    logic rd;              // Flag read, core domain pulse
    logic parity_pulse;    // Parity error, core domain pulse
    logic wd_now;          // Watchdog past half this cycle
    logic sel_hit;         // Timer reaches limit this cycle
    diag_flag_pkg::event_flags_s ev_set;  // Event set terms

    // ------------------------------------------------------------
    // Link crossings
    // ------------------------------------------------------------
    // Read command from the frame decoder
    pulse_crossing u_read_cross (
        .src_clk(spi_clk),
        .src_pulse(link_flag_read),
        .dst_clk(clk),
        .dst_pulse(rd),
        .rst_n(rst_n)
    );

    // Parity error from the frame decoder
    pulse_crossing u_parity_cross (
        .src_clk(spi_clk),
        .src_pulse(link_parity_error),
        .dst_clk(clk),
        .dst_pulse(parity_pulse),
        .rst_n(rst_n)
    );

    // ------------------------------------------------------------
    // Set terms
    // ------------------------------------------------------------
    // Fraction compare; widened so the product cannot wrap
    always_comb begin
        logic [WD_W+6:0] lhs;
        logic [WD_W+6:0] rhs;
        lhs = {7'd0, wd_elapsed} * {{WD_W{1'b0}}, `WD_FULL_PCT};
        rhs = {7'd0, wd_period} * {{WD_W{1'b0}}, `WD_FLASH_PCT};
        wd_now = flash_mode && (lhs > rhs);  // [R7]
    end

    // Limit match, one cycle per low period; a release that lands on the
    // limit cycle wins, so the timer never flags a frame that ended
    assign sel_hit = (st.sel_state == diag_flag_pkg::SEL_TIMING) &&
        !st.sel_s2 &&                                        // [R4]
        (st.sel_count == CNT_W'(SEL_TIMEOUT_CYCLES - 1));

    // Event set terms
    always_comb begin
        ev_set = '0;
        ev_set.parity_err = parity_pulse;                    // [R3]
        ev_set.select_timeout = sel_hit;                     // [R4]
        ev_set.wd_flash_half = wd_now && !st.wd_over;        // [R7]
        ev_set.wake_io13 = evt_in.wake_io13;                 // [R8]
        ev_set.wake_io02 = evt_in.wake_io02;                 // [R9]
        ev_set.wake_spi = evt_in.spi_wake &&
            low_power_regulator_on_mode;                     // [R10]
        ev_set.wake_forced = evt_in.timer_forced_wakeup;     // [R11]
        ev_set.int_timeout = evt_in.int_service_expired;     // [R12]
        ev_set.lp_off_seen =
            evt_in.low_power_regulator_off_mode_select;      // [R13]
        // Cause level caught on the first edge after release
        ev_set.reset_request = !st.armed &&
            reset_by_spi_request;                            // [R14]
        // Falling comparator while in debug
        ev_set.debug_exit = debug_mode_active && st.dbg_prev &&
            !st.dbg_s2;                                      // [R15]
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Synchronisers, first stage feeds second only
        next_st.fault_s1 = fault_in;
        next_st.fault_s2 = st.fault_s1;
        next_st.sel_s1 = spi_select_line_n;
        next_st.sel_s2 = st.sel_s1;
        next_st.dbg_s1 = debug_entry_pin_high;
        next_st.dbg_s2 = st.dbg_s1;
        next_st.dbg_prev = st.dbg_s2;
        next_st.wd_over = wd_now;
        next_st.armed = 1'b1;
        // Select low timer
        case (st.sel_state)
            diag_flag_pkg::SEL_IDLE: begin
                next_st.sel_count = '0;
                if (!st.sel_s2) begin
                    next_st.sel_state = diag_flag_pkg::SEL_TIMING;
                end
            end
            diag_flag_pkg::SEL_TIMING: begin
                if (st.sel_s2) begin
                    // Frame ended in time
                    next_st.sel_state = diag_flag_pkg::SEL_IDLE;
                    next_st.sel_count = '0;
                end else if (sel_hit) begin
                    next_st.sel_state = diag_flag_pkg::SEL_EXPIRED;
                end else begin
                    next_st.sel_count = st.sel_count + 1'b1;
                end
            end
            diag_flag_pkg::SEL_EXPIRED: begin
                // Flag once, then wait for release
                if (st.sel_s2) begin
                    next_st.sel_state = diag_flag_pkg::SEL_IDLE;
                    next_st.sel_count = '0;
                end
            end
            default: begin
                next_st.sel_state = diag_flag_pkg::SEL_IDLE;
                next_st.sel_count = '0;
            end
        endcase
        // Read snapshot holds values before clearing
        next_st.read_valid = rd;                             // [R17]
        if (rd) begin
            next_st.read_data = st.flags;                    // [R17]
        end
        // Live condition keeps its flag through a read
        next_st.flags.fault = st.fault_s2 |  // [R1] [R2] [R5] [R6]
            (st.flags.fault & ~{$bits(st.flags.fault){rd}});
        // Set wins over a read in the same cycle
        next_st.flags.evt = ev_set |
            (st.flags.evt & ~{$bits(st.flags.evt){rd}});     // [R17]
        // Plain copy, reads never touch it
        next_st.rt = rt_state_in;                            // [R16]
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.sel_s1 <= `SEL_IDLE_LEVEL;
            st.sel_s2 <= `SEL_IDLE_LEVEL;
            st.flags <= {$bits(st.flags){`FLAG_RESET_VALUE}};
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign flags = st.flags;
    assign read_data = st.read_data;
    assign read_valid = st.read_valid;
    assign rt_state = st.rt;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_read_with_fault;
        rd && st.fault_s2.hs2_gnd;
    endsequence

    sequence s_dbg_fall;
        debug_mode_active && st.dbg_prev && !st.dbg_s2;
    endsequence

    property p_line_short_set;
        st.fault_s2.canl_gnd |=> flags.fault.canl_gnd;
    endproperty
    a_line_short_set: assert property (p_line_short_set) // [R1]
        else $error("line short flag not set");

    property p_switch_kept;
        s_read_with_fault |=> flags.fault.hs2_gnd;
    endproperty
    a_switch_kept: assert property (p_switch_kept) // [R2]
        else $error("switch flag cleared while fault live");

    property p_parity_set;
        parity_pulse |=> flags.evt.parity_err;
    endproperty
    a_parity_set: assert property (p_parity_set) // [R3]
        else $error("parity flag not set");

    property p_sel_timeout;
        sel_hit |=> flags.evt.select_timeout &&
            st.sel_state == diag_flag_pkg::SEL_EXPIRED;
    endproperty
    a_sel_timeout: assert property (p_sel_timeout) // [R4]
        else $error("select timeout not flagged");

    property p_supply_hold;
        flags.fault.sup2_uv && !rd |=> flags.fault.sup2_uv;
    endproperty
    a_supply_hold: assert property (p_supply_hold) // [R5]
        else $error("supply flag dropped without read");

    property p_thermal_clear;
        rd && !st.fault_s2.hs0_therm |=> !flags.fault.hs0_therm;
    endproperty
    a_thermal_clear: assert property (p_thermal_clear) // [R6]
        else $error("thermal flag not cleared");

    property p_wd_half;
        $rose(wd_now) |=> flags.evt.wd_flash_half;
    endproperty
    a_wd_half: assert property (p_wd_half) // [R7]
        else $error("watchdog half flag missed");

    property p_wake_spi_mode;
        !flags.evt.wake_spi && !low_power_regulator_on_mode |=>
            !flags.evt.wake_spi;
    endproperty
    a_wake_spi_mode: assert property (p_wake_spi_mode) // [R10]
        else $error("command wake flagged outside mode");

    property p_reset_cause;
        !st.armed && reset_by_spi_request |=> flags.evt.reset_request;
    endproperty
    a_reset_cause: assert property (p_reset_cause) // [R14]
        else $error("reset request not recorded");

    property p_dbg_exit;
        s_dbg_fall |=> flags.evt.debug_exit;
    endproperty
    a_dbg_exit: assert property (p_dbg_exit) // [R15]
        else $error("debug exit not flagged");

    property p_rt_copy;
        ##1 rt_state == $past(rt_state_in);
    endproperty
    a_rt_copy: assert property (p_rt_copy) // [R16]
        else $error("real-time copy wrong");

    property p_read_snapshot;
        rd |=> read_valid && read_data == $past(flags) ##1 !read_valid;
    endproperty
    a_read_snapshot: assert property (p_read_snapshot) // [R17]
        else $error("read snapshot wrong");

    property p_event_survives_read;
        rd && evt_in.wake_io13 |=> flags.evt.wake_io13;
    endproperty
    a_event_survives_read: assert property (p_event_survives_read) // [R8]
        else $error("event lost on read");

endmodule

// *** testbench/spi_host_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Host side of the serial link
// ----------------------------------------------------------------
module spi_host_model (
    // Link toward the flag bank
    output logic spi_clk,
    output logic flag_read,
    output logic parity_error,
    output logic select_n
);
    // Idle link: select high, clock parked low between frames
    initial begin
        spi_clk = 1'b0;
        flag_read = 1'b0;
        parity_error = 1'b0;
        select_n = 1'b1;
    end

    // One frame with a single command cycle; low_ns stretches select
    task automatic frame(input logic rd, input logic par, input int low_ns);
        select_n = 1'b0;
        #(low_ns + 3);
        flag_read = rd;
        parity_error = par;
        #3 spi_clk = 1'b1;
        // Released only after the sampling edge
        #1 flag_read = 1'b0;
        parity_error = 1'b0;
        #2 spi_clk = 1'b0;
        #3 select_n = 1'b1;
    endtask
endmodule

// *** testbench/test_diag_flag_bank.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Self-checking bench for the flag bank
// ----------------------------------------------------------------
module test_diag_flag_bank;
    // Clock, reset and stimulus
    logic clk, rst_n, spi_clk, link_flag_read, link_parity_error;
    logic spi_select_line_n, debug_entry_pin_high, debug_mode_active;
    logic flash_mode, low_power_regulator_on_mode, reset_by_spi_request;
    logic read_valid, lp;
    logic [15:0] wd_elapsed, wd_period;
    logic [7:0] rt_state_in, rt_state;
    logic [10:0] f;
    logic [5:0] e;
    diag_flag_pkg::fault_flags_s fault_in;
    diag_flag_pkg::event_sources_s evt_in;
    diag_flag_pkg::flag_bank_s flags, read_data, exp;
    // Oldest note, taken off the queue by the watcher
    diag_flag_pkg::flag_bank_s want_rd;
    // Expected snapshots, oldest first
    diag_flag_pkg::flag_bank_s notes[$];
    int num_errors, checks_done, reads_seen, cycles;

    // Short select limit keeps the run brief
    diag_flag_bank #(.CNT_W(16), .SEL_TIMEOUT_CYCLES(20)) dut_u (
        .clk(clk), .rst_n(rst_n), .spi_clk(spi_clk),
        .link_flag_read(link_flag_read),
        .link_parity_error(link_parity_error),
        .fault_in(fault_in), .spi_select_line_n(spi_select_line_n),
        .debug_entry_pin_high(debug_entry_pin_high),
        .debug_mode_active(debug_mode_active), .flash_mode(flash_mode),
        .wd_elapsed(wd_elapsed), .wd_period(wd_period), .evt_in(evt_in),
        .low_power_regulator_on_mode(low_power_regulator_on_mode),
        .reset_by_spi_request(reset_by_spi_request),
        .rt_state_in(rt_state_in), .flags(flags), .read_data(read_data),
        .read_valid(read_valid), .rt_state(rt_state)
    );

    // Host model drives the whole link side
    spi_host_model host_u (
        .spi_clk(spi_clk), .flag_read(link_flag_read),
        .parity_error(link_parity_error), .select_n(spi_select_line_n)
    );

    // 25 MHz core clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask

    task automatic wrap_up();
        $display("errors %0d, checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Read: note the snapshot, send the command, expect the clear
    task automatic do_read();
        int n;
        #1;
        n = reads_seen;
        check("flags before read", 32'(flags), 32'(exp));
        notes.push_back(exp);
        host_u.frame(1'b1, 1'b0, 0);
        for (int i = 0; i < 12 && reads_seen == n; i++) @(posedge clk);
        check("read count", 32'(reads_seen), 32'(n + 1));
        // Faults stay while live, events drop
        exp.evt = '0;
        // A source still high during the read sets again
        exp.evt.wake_io13 = evt_in.wake_io13;
        exp.fault = fault_in;
        tick(2);
        #1;
        check("flags after read", 32'(flags), 32'(exp));
    endtask

    // Result watcher: each read answer meets the oldest note
    always @(posedge clk) begin
        if (read_valid === 1'b1) begin
            reads_seen++;
            if (notes.size() == 0)
                check("read without note", 32'h1, 32'h0);
            else begin
                want_rd = notes.pop_front();
                check("read_data", 32'(read_data), 32'(want_rd));
            end
        end
    end

    // Hang guard, far beyond the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(183));
        rst_n = 1'b0;
        fault_in = '0;
        evt_in = '0;
        debug_entry_pin_high = 1'b0;
        debug_mode_active = 1'b0;
        flash_mode = 1'b0;
        low_power_regulator_on_mode = 1'b0;
        reset_by_spi_request = 1'b1;
        wd_elapsed = '0;
        wd_period = 16'd100;
        rt_state_in = '0;
        exp = '0;
        tick(2);
        rst_n <= 1'b1;
        // Request level is captured on the first edge after release
        @(posedge clk);
        reset_by_spi_request <= 1'b0;
        exp.evt.reset_request = 1'b1;
        tick(3);
        do_read();
        tick(3);
        do_read();
        // Random faults: sticky until gone and read
        // Thermal, switch two, supply two and a line short always live
        f = 11'($urandom) | 11'h02d;
        @(posedge clk);
        fault_in <= f;
        exp.fault = f;
        tick(5);
        do_read();
        @(posedge clk);
        fault_in <= '0;
        tick(5);
        do_read();
        // Every event source, command wake only in regulator-on mode
        for (int i = 0; i < 6; i++) begin
            e = 6'(1 << i) | 6'($urandom);
            lp = (i == 3) | 1'($urandom);
            @(posedge clk);
            evt_in <= e;
            low_power_regulator_on_mode <= lp;
            @(posedge clk);
            evt_in <= '0;
            exp.evt[7:2] = exp.evt[7:2] | (lp ? e : (e & 6'h37));
        end
        tick(2);
        do_read();
        // Parity error frame
        host_u.frame(1'b0, 1'b1, 0);
        exp.evt.parity_err = 1'b1;
        tick(8);
        do_read();
        // Select held low well past the limit
        host_u.frame(1'b0, 1'b0, 1200);
        exp.evt.select_timeout = 1'b1;
        tick(4);
        do_read();
        // Watchdog: outside flash mode, at half, then just past half
        @(posedge clk);
        wd_elapsed <= 16'd80;
        tick(3);
        flash_mode <= 1'b1;
        wd_elapsed <= 16'd50;
        tick(3);
        wd_elapsed <= 16'd51;
        exp.evt.wd_flash_half = 1'b1;
        tick(3);
        do_read();
        @(posedge clk);
        flash_mode <= 1'b0;
        // Debug left by the pin falling
        debug_mode_active <= 1'b1;
        debug_entry_pin_high <= 1'b1;
        tick(4);
        debug_entry_pin_high <= 1'b0;
        exp.evt.debug_exit = 1'b1;
        tick(6);
        debug_mode_active <= 1'b0;
        do_read();
        // Wake source held high across a read: set beats the clear
        @(posedge clk);
        evt_in <= 6'h20;
        exp.evt.wake_io13 = 1'b1;
        tick(2);
        do_read();
        @(posedge clk);
        evt_in <= '0;
        // Live indicators pass through and survive a read
        @(posedge clk);
        rt_state_in <= 8'($urandom);
        tick(2);
        #1;
        check("rt_state", 32'(rt_state), 32'(rt_state_in));
        do_read();
        check("rt_state after read", 32'(rt_state), 32'(rt_state_in));
        wrap_up();
    end
endmodule
